// *** rtl/ebt_pkg.sv ***
// Package of constants and carriers for the EISA/ISA bus translation block
// Functional notes
// - Sample slave-burst when command asserts; keep sampling each rise until negated.
// - Command stays asserted through the whole burst, not pulsed per transfer.
// - In DMA burst, drive master-burst on falling edge after slave-burst seen.
// - Sample 16-bit-master at start rise; asserted means 16-bit or ISA master.
// - Negated first, asserted later: 32-bit master downshifted, disable size translation.
// - Drive low data on internal register reads and interrupt acknowledge; input on writes.
// - Address latch enable marks address valid; slaves latch upper address on its fall.
// - Address latch enable stays active through DMA, ISA master and refresh cycles.
// - In ISA master cycles except refresh, byte enables derive from low address and high-byte.
// - In EISA master and DMA cycles, drive low address bits from byte enables.
// - Drive high-byte enable in EISA master and DMA cycles; asserted means upper byte valid.
// - Memory 16 select is output under ISA master; asserted when either slave-width is asserted.
// - Never claim 16-bit I/O width for own registers; always 8-bit cycles.
// - Drive command strobes while owning ISA bus; inputs under external ISA master.
// - Drive memory-read command during refresh cycles.
// - System memory strobes only for addresses below 1 MByte.
// - System memory read strobe also asserted during every refresh.
// - Ready is input when owning bus or compatible DMA; output for PCI or register targets.
// - Ignore channel ready entirely when ISA master accesses an ISA slave.
// - Channel check raises non-maskable interrupt when reporting is enabled.
// - Command asserts at the rise where start negates and holds to cycle end.
package ebt_pkg;
    // Synchroniser stage count for pin inputs
    localparam int unsigned SYNC_STAGES = 2;
    // Upper address bits that mark 1 MByte and above
    localparam int unsigned ADDR_W      = 24;
    localparam int unsigned MEG_LSB     = 20;
    // Cycle owner kinds
    typedef enum logic [2:0] {
        EBT_OWN_IDLE,
        EBT_OWN_EISA,
        EBT_OWN_ISA,
        EBT_OWN_DMA,
        EBT_OWN_REF_INT,
        EBT_OWN_REF_ISA
    } ebt_owner_e;
    // Command strobes, active low
    typedef struct packed {
        logic mrd_n;
        logic mwr_n;
        logic iord_n;
        logic iowr_n;
    } ebt_cmd_s;
    // Byte-lane address carrier
    typedef struct packed {
        logic [1:0] sa;
        logic       sbhe_n;
    } ebt_lane_s;
    localparam ebt_cmd_s CMD_IDLE = '{mrd_n: 1'b1, mwr_n: 1'b1, iord_n: 1'b1, iowr_n: 1'b1};
endpackage : ebt_pkg

// *** rtl/ebt_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ebt_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    // First stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : ebt_sync
`default_nettype wire

// *** rtl/ebt_lane_map.sv ***
// Byte enable and ISA lane translation
`timescale 1ns/100ps
`default_nettype none
module ebt_lane_map (
    input  wire logic             [3:0] be_n_in,
    input  wire ebt_pkg::ebt_lane_s     lane_in,
    output logic                  [3:0] be_n_out,
    output ebt_pkg::ebt_lane_s          lane_out
);
    import ebt_pkg::*;
    // ISA address and high-byte to EISA byte enables
    logic [3:0] be_act;
    always_comb begin
        be_act        = 4'h0;
        be_act[{lane_in.sa[1], 1'b0}] = ~lane_in.sa[0];
        be_act[{lane_in.sa[1], 1'b1}] = lane_in.sa[0] | ~lane_in.sbhe_n;
    end
    assign be_n_out = ~be_act;
    // Byte enables to ISA address and high-byte
    wire [3:0] be = ~be_n_in;
    wire lo_half  = be[0] | be[1];
    wire first_odd = lo_half ? (~be[0] & be[1]) : (~be[2] & be[3]);
    assign lane_out.sa     = {~lo_half, first_odd};
    assign lane_out.sbhe_n = ~(lo_half ? be[1] : be[3]);
endmodule : ebt_lane_map
`default_nettype wire

// *** rtl/ebt_bus_xlate.sv ***
// EISA/ISA bus translation control top
`timescale 1ns/100ps
`default_nettype none
module ebt_bus_xlate (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                bclk,
    input  wire ebt_pkg::ebt_owner_e owner,
    input  wire logic                dma_burst,
    input  wire logic                dma_compat,
    input  wire logic                start_n,
    input  wire logic                slburst_n,
    input  wire logic                master16_n,
    input  wire logic                msburst_n_in,
    output logic                     msburst_n_out,
    output logic                     msburst_oe,
    output logic                     cmd_n,
    output logic                     burst_active,
    output logic                     master16_seen,
    output logic                     size_xlate_dis,
    input  wire logic                reg_io_rd,
    input  wire logic                reg_io_wr,
    input  wire logic                inta_cycle,
    input  wire logic          [7:0] reg_rd_data,
    input  wire logic          [7:0] sd_in,
    output logic               [7:0] sd_out,
    output logic                     sd_oe,
    output logic               [7:0] reg_wr_data,
    output logic                     reg_wr_stb,
    input  wire logic                addr_valid,
    output logic                     bale,
    input  wire logic          [3:0] be_n_in,
    output logic               [3:0] be_n_out,
    output logic                     be_oe,
    input  wire ebt_pkg::ebt_lane_s  lane_in,
    output ebt_pkg::ebt_lane_s       lane_out,
    output logic                     lane_oe,
    input  wire logic                ex32_n,
    input  wire logic                ex16_n,
    output logic                     m16_n_out,
    output logic                     m16_oe,
    output logic                     io16_n_out,
    output logic                     io16_oe,
    input  wire ebt_pkg::ebt_cmd_s   cmd_req,
    input  wire ebt_pkg::ebt_cmd_s   cmd_in,
    output ebt_pkg::ebt_cmd_s        cmd_out,
    output logic                     cmd_oe,
    output ebt_pkg::ebt_cmd_s        cmd_seen,
    input  wire logic   [ebt_pkg::ADDR_W-1:0] mem_addr,
    output logic                     smrd_n,
    output logic                     smwr_n,
    input  wire logic                isa_tgt_internal,
    input  wire logic                int_ready,
    input  wire logic                chrdy_in,
    output logic                     chrdy_out,
    output logic                     chrdy_oe,
    output logic                     chrdy_seen,
    input  wire logic                iochk_n,
    input  wire logic                nmi_enable,
    output logic                     nmi
);
    import ebt_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [5:0] pin_raw;
    logic [5:0] pin_s;
    // Active-low pins enter inverted so the cleared synchroniser reads as idle
    assign pin_raw = {bclk, ~start_n, ~slburst_n, ~master16_n, ~chrdy_in, ~iochk_n};
    ebt_sync #(.W(6)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (pin_raw),
        .q   (pin_s)
    );
    wire bclk_s     = pin_s[5];
    wire start_s_n  = ~pin_s[4];
    wire slburst_sn = ~pin_s[3];
    wire m16m_sn    = ~pin_s[2];
    wire chrdy_s    = ~pin_s[1];
    wire iochk_sn   = ~pin_s[0];

    // ------------------------------------------------------------
    // Bus clock edge detection
    // ------------------------------------------------------------
    logic bclk_d_reg;
    logic start_d_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bclk_d_reg  <= 1'b0;
            start_d_reg <= 1'b1;
        end else begin
            bclk_d_reg  <= bclk_s;
            if (bclk_s & ~bclk_d_reg)
                start_d_reg <= start_s_n;
        end
    end
    wire bclk_rise = bclk_s & ~bclk_d_reg;
    wire bclk_fall = ~bclk_s & bclk_d_reg;
    // Start asserted at this rise, or negated after being asserted
    wire start_rise = bclk_rise & ~start_s_n;
    wire start_end  = bclk_rise & start_s_n & ~start_d_reg;

    // ------------------------------------------------------------
    // EISA cycle state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EBT_CYC_IDLE,
        EBT_CYC_START,
        EBT_CYC_CMD,
        EBT_CYC_BURST
    } ebt_cyc_e;
    ebt_cyc_e cyc_reg;
    ebt_cyc_e cyc_next;
    logic     m16_first_reg;
    logic     msb_pend_reg;

    // Command follows end of start; burst keeps it held
    always_comb begin
        cyc_next = cyc_reg;
        case (cyc_reg)
            EBT_CYC_IDLE:  if (start_rise) cyc_next = EBT_CYC_START;
            EBT_CYC_START: if (start_end) cyc_next = slburst_sn ? EBT_CYC_CMD : EBT_CYC_BURST;
            EBT_CYC_CMD:   if (bclk_rise) cyc_next = EBT_CYC_IDLE;
            EBT_CYC_BURST: if (bclk_rise && slburst_sn) cyc_next = EBT_CYC_IDLE;
            default:       cyc_next = EBT_CYC_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            cyc_reg <= EBT_CYC_IDLE;
        else
            cyc_reg <= cyc_next;
    end

    assign cmd_n        = ~(cyc_reg == EBT_CYC_CMD || cyc_reg == EBT_CYC_BURST);
    assign burst_active = (cyc_reg == EBT_CYC_BURST);

    // ------------------------------------------------------------
    // 16-bit master detection and downshift
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            m16_first_reg  <= 1'b0;
            master16_seen  <= 1'b0;
            size_xlate_dis <= 1'b0;
        end else if (start_rise) begin
            m16_first_reg  <= ~m16m_sn;
            master16_seen  <= ~m16m_sn;
            size_xlate_dis <= 1'b0;
        end else if (start_end && !m16_first_reg && !m16m_sn) begin
            size_xlate_dis <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // DMA master-burst drive on the falling edge
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msb_pend_reg  <= 1'b0;
            msburst_n_out <= 1'b1;
        end else begin
            if (owner == EBT_OWN_DMA && dma_burst && start_end && !slburst_sn)
                msb_pend_reg <= 1'b1;
            else if (bclk_fall)
                msb_pend_reg <= 1'b0;
            if (bclk_fall && msb_pend_reg)
                msburst_n_out <= 1'b0;
            else if (cyc_reg == EBT_CYC_IDLE)
                msburst_n_out <= 1'b1;
        end
    end
    assign msburst_oe = (owner == EBT_OWN_DMA) & dma_burst;

    // ------------------------------------------------------------
    // System data low byte
    // ------------------------------------------------------------
    wire sd_drive = reg_io_rd | inta_cycle;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sd_out      <= 8'h00;
            reg_wr_data <= 8'h00;
            reg_wr_stb  <= 1'b0;
        end else begin
            sd_out      <= reg_rd_data;
            reg_wr_stb  <= reg_io_wr;
            if (reg_io_wr)
                reg_wr_data <= sd_in;
        end
    end
    assign sd_oe = sd_drive & ~reg_io_wr;

    // ------------------------------------------------------------
    // Address latch enable
    // ------------------------------------------------------------
    wire long_bale = owner == EBT_OWN_DMA || owner == EBT_OWN_ISA ||
                     owner == EBT_OWN_REF_INT || owner == EBT_OWN_REF_ISA;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            bale <= 1'b0;
        else
            bale <= long_bale | addr_valid;
    end

    // ------------------------------------------------------------
    // Byte lane translation and pin directions
    // ------------------------------------------------------------
    ebt_lane_map u_lane (
        .be_n_in  (be_n_in),
        .lane_in  (lane_in),
        .be_n_out (be_n_out),
        .lane_out (lane_out)
    );
    wire own_isa = (owner == EBT_OWN_ISA);
    // An ISA master or an ISA-master refresh takes the ISA side away from us
    wire own_ext = own_isa | (owner == EBT_OWN_REF_ISA);
    assign be_oe   = own_isa;
    assign lane_oe = (owner == EBT_OWN_EISA) | (owner == EBT_OWN_DMA);

    // ------------------------------------------------------------
    // Chip selects
    // ------------------------------------------------------------
    assign m16_oe     = own_isa & (~ex32_n | ~ex16_n);
    assign m16_n_out  = 1'b0;
    assign io16_oe    = 1'b0;
    assign io16_n_out = 1'b1;

    // ------------------------------------------------------------
    // Command strobes
    // ------------------------------------------------------------
    wire refresh = (owner == EBT_OWN_REF_INT) | (owner == EBT_OWN_REF_ISA);
    wire own_bus = ~own_ext | (owner == EBT_OWN_REF_ISA);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_out  <= CMD_IDLE;
            cmd_seen <= CMD_IDLE;
        end else begin
            cmd_out       <= '{mrd_n: cmd_req.mrd_n & ~refresh, mwr_n: cmd_req.mwr_n,
                               iord_n: cmd_req.iord_n, iowr_n: cmd_req.iowr_n};
            cmd_seen      <= own_ext ? cmd_in : CMD_IDLE;
        end
    end
    assign cmd_oe = own_bus & (owner != EBT_OWN_IDLE);

    // System memory strobes below 1 MByte, read also in refresh
    wire below_meg = ~|mem_addr[ADDR_W-1:MEG_LSB];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            smrd_n <= 1'b1;
            smwr_n <= 1'b1;
        end else begin
            smrd_n <= ~((~cmd_req.mrd_n & below_meg) | refresh);
            smwr_n <= ~(~cmd_req.mwr_n & below_meg);
        end
    end

    // ------------------------------------------------------------
    // Channel ready
    // ------------------------------------------------------------
    assign chrdy_oe   = own_isa & isa_tgt_internal;
    assign chrdy_out  = int_ready;
    // Ready from ISA slaves is disregarded under an ISA master
    assign chrdy_seen = (own_isa & ~isa_tgt_internal) ? 1'b1 :
                        ((~own_ext | dma_compat) ? chrdy_s : 1'b1);

    // ------------------------------------------------------------
    // Channel check to non-maskable interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            nmi <= 1'b0;
        else
            nmi <= ~iochk_sn & nmi_enable;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_start_end;
        start_end && cyc_reg == EBT_CYC_START;
    endsequence
    property p_cmd_on_start_end;
        @(posedge clk) disable iff (rst) s_start_end |=> !cmd_n;
    endproperty
    a_cmd_on_start_end: assert property (p_cmd_on_start_end) else $error("cmd not asserted");
    property p_burst_holds;
        @(posedge clk) disable iff (rst) (burst_active && !(bclk_rise && slburst_sn)) |=> !cmd_n;
    endproperty
    a_burst_holds: assert property (p_burst_holds) else $error("cmd dropped in burst");
    property p_burst_exit;
        @(posedge clk) disable iff (rst) (burst_active && bclk_rise && slburst_sn) |=> cmd_n;
    endproperty
    a_burst_exit: assert property (p_burst_exit) else $error("burst not ended");
    property p_downshift;
        @(posedge clk) disable iff (rst) (start_end && !m16_first_reg && !m16m_sn) |=> size_xlate_dis;
    endproperty
    a_downshift: assert property (p_downshift) else $error("downshift missed");
    property p_m16_sample;
        @(posedge clk) disable iff (rst) start_rise |=> master16_seen != $past(m16m_sn);
    endproperty
    a_m16_sample: assert property (p_m16_sample) else $error("master16 wrong");
    property p_bale_long;
        @(posedge clk) disable iff (rst) long_bale |=> bale;
    endproperty
    a_bale_long: assert property (p_bale_long) else $error("bale dropped");
    property p_smwr_high;
        @(posedge clk) disable iff (rst) !below_meg |=> smwr_n;
    endproperty
    a_smwr_high: assert property (p_smwr_high) else $error("smwr above meg");
    property p_refresh_rd;
        @(posedge clk) disable iff (rst) refresh |=> (!smrd_n && !cmd_out.mrd_n);
    endproperty
    a_refresh_rd: assert property (p_refresh_rd) else $error("refresh read missing");
    property p_io16_off;
        @(posedge clk) disable iff (rst) !io16_oe;
    endproperty
    a_io16_off: assert property (p_io16_off) else $error("io16 driven");
    property p_nmi;
        @(posedge clk) disable iff (rst) (!iochk_sn && nmi_enable) |=> nmi;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi missing");
    property p_float_ext;
        @(posedge clk) disable iff (rst) own_isa |-> (!cmd_oe && !lane_oe);
    endproperty
    a_float_ext: assert property (p_float_ext) else $error("contention");
endmodule : ebt_bus_xlate
`default_nettype wire

// *** testbench/ebt_far_model.sv ***
// Far-side EISA master and slave model: bus clock and cycle pins
`timescale 1ns/100ps
`default_nettype none
module ebt_far_model (
    output logic bclk,
    output logic start_n,
    output logic slburst_n,
    output logic master16_n,
    output logic msburst_n
);
    // Pulled-up pins idle high
    initial begin
        bclk = 1'b0;
        start_n = 1'b1;
        slburst_n = 1'b1;
        master16_n = 1'b1;
        msburst_n = 1'b1;
    end
    // Free-running bus clock, 400 ns
    always #200 bclk = ~bclk;
    // One cycle; pins move on the fall so the rise sees them settled
    task cycle(input int nb, input logic m16a, input logic m16b);
        begin
            @(negedge bclk);
            start_n <= 1'b0;
            master16_n <= m16a;
            slburst_n <= (nb > 0) ? 1'b0 : 1'b1;
            @(negedge bclk);
            start_n <= 1'b1;
            master16_n <= m16b;
            repeat (nb) begin
                @(negedge bclk);
                msburst_n <= 1'b0;
            end
            @(negedge bclk);
            slburst_n <= 1'b1;
            msburst_n <= 1'b1;
            master16_n <= 1'b1;
            repeat (2) @(negedge bclk);
        end
    endtask : cycle
endmodule : ebt_far_model
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the bus translation control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ebt_pkg::*;
    // -------------------------------------------------------------
    // Stimulus, observed outputs and helpers
    // -------------------------------------------------------------
    logic        clk = 1'b0, rst = 1'b1, bclk, start_n, slburst_n, master16_n, msburst_n_in;
    ebt_owner_e  owner = EBT_OWN_IDLE;
    logic        dma_burst = 1'b0, dma_compat = 1'b0, reg_io_rd = 1'b0, reg_io_wr = 1'b0, inta_cycle = 1'b0;
    logic        addr_valid = 1'b0, ex32_n = 1'b1, ex16_n = 1'b1, isa_tgt_internal = 1'b0, int_ready = 1'b1;
    logic        chrdy_in = 1'b1, iochk_n = 1'b1, nmi_enable = 1'b0;
    logic [7:0]  reg_rd_data = 8'h00, sd_in = 8'h00, sd_out, reg_wr_data;
    logic [3:0]  be_n_in = 4'hf, be_n_out;
    logic [23:0] mem_addr = 24'h000000;
    ebt_lane_s   lane_in = '0, lane_out;
    ebt_cmd_s    cmd_req = CMD_IDLE, cmd_in = CMD_IDLE, cmd_out, cmd_seen;
    logic        msburst_n_out, msburst_oe, cmd_n, burst_active, master16_seen, size_xlate_dis, sd_oe;
    logic        reg_wr_stb, bale, be_oe, lane_oe, m16_n_out, m16_oe, io16_n_out, io16_oe, cmd_oe;
    logic        smrd_n, smwr_n, chrdy_out, chrdy_oe, chrdy_seen, nmi, ms, ba, ea;
    logic [1:0]  sx;
    logic [31:0] r, q;
    int          n_fail = 0, tests_run = 0, seed, i, mx;
    logic [3:0]  be_tab [8] = '{4'he, 4'hd, 4'hc, 4'hb, 4'h7, 4'h3, 4'he, 4'h3};
    // -------------------------------------------------------------

    always #25 clk = ~clk;

    ebt_far_model far (.bclk, .start_n, .slburst_n, .master16_n, .msburst_n(msburst_n_in));
    ebt_bus_xlate dut (
        .clk, .rst, .bclk, .owner, .dma_burst, .dma_compat, .start_n, .slburst_n, .master16_n,
        .msburst_n_in, .msburst_n_out, .msburst_oe, .cmd_n, .burst_active, .master16_seen, .size_xlate_dis,
        .reg_io_rd, .reg_io_wr, .inta_cycle, .reg_rd_data, .sd_in, .sd_out, .sd_oe, .reg_wr_data,
        .reg_wr_stb, .addr_valid, .bale, .be_n_in, .be_n_out, .be_oe, .lane_in, .lane_out, .lane_oe,
        .ex32_n, .ex16_n, .m16_n_out, .m16_oe, .io16_n_out, .io16_oe, .cmd_req, .cmd_in, .cmd_out,
        .cmd_oe, .cmd_seen, .mem_addr, .smrd_n, .smwr_n, .isa_tgt_internal, .int_ready, .chrdy_in,
        .chrdy_out, .chrdy_oe, .chrdy_seen, .iochk_n, .nmi_enable, .nmi
    );

    // Compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            tests_run++;
            if (g !== e) begin
                n_fail++;
                $display("BAD %s expected %h seen %h", nm, e, g);
            end
        end
    endtask : chk

    // Counts and verdict
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask : test_done

    // Let synchronisers and registers catch up
    task settle;
        repeat (5) @(negedge clk);
    endtask : settle

    // Byte enables implied by low address and high-byte enable
    function automatic logic [3:0] be_of(input ebt_lane_s l);
        logic [3:0] m;
        begin
            m = (4'h1 << l.sa) | ((l.sbhe_n || l.sa[0]) ? 4'h0 : (4'h2 << l.sa));
            be_of = ~m;
        end
    endfunction : be_of

    // Low address and high-byte enable for a one-half enable pattern
    function automatic ebt_lane_s lane_of(input logic [3:0] b);
        ebt_lane_s l;
        begin
            l.sa = b[0] ? (b[1] ? (b[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
            l.sbhe_n = b[1] & b[3];
            lane_of = l;
        end
    endfunction : lane_of

    // Run one far-side cycle while watching command and burst pins
    task run_cyc(input int nb, input logic a, input logic b);
        int run;
        begin
            run = 0;
            mx = 0;
            {ms, ba, ea} = 3'b000;
            fork
                far.cycle(nb, a, b);
                repeat ((nb + 5) * 8) begin
                    @(negedge clk);
                    run = (cmd_n === 1'b0) ? run + 1 : 0;
                    if (run > mx) mx = run;
                    if (msburst_oe === 1'b1 && msburst_n_out === 1'b0) ms = 1'b1;
                    if (burst_active === 1'b1) ba = 1'b1;
                    if (cmd_n === 1'b0 && start_n === 1'b0) ea = 1'b1;
                end
            join
        end
    endtask : run_cyc

    // Main sequence
    initial begin
        seed = 3;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("reset_outs", 6'b100111, {cmd_n, bale, nmi, smrd_n, smwr_n, msburst_n_out});
        @(posedge clk);
        rst <= 1'b0;
        owner <= EBT_OWN_EISA;
        repeat (3) @(posedge clk);
        for (i = 0; i < 3; i++) begin
            q = (i == 2) ? 3 : i;
            run_cyc(q, 1'b1, 1'b1);
            chk("cmd_low_len", 1, (mx >= q * 8 + 7) && (mx <= q * 8 + 9));
            chk("cmd_early", 0, ea);
            chk("burst_active", q != 0, ba);
            chk("msburst_eisa", 0, ms);
        end
        @(posedge clk);
        owner <= EBT_OWN_DMA;
        dma_burst <= 1'b1;
        run_cyc(2, 1'b1, 1'b1);
        chk("msburst_dma", 1, ms);
        chk("bale_dma", 1, bale);
        @(posedge clk);
        owner <= EBT_OWN_EISA;
        dma_burst <= 1'b0;
        for (i = 0; i < 3; i++) begin
            run_cyc(0, i != 0, i == 2);
            chk("master16_seen", i == 0, master16_seen);
            chk("size_xlate_dis", i == 1, size_xlate_dis);
        end
        $display("cycle and burst tests done");
        for (i = 0; i < 24; i++) begin
            r = $random(seed);
            q = $random(seed);
            @(posedge clk);
            owner <= EBT_OWN_ISA;
            lane_in <= r[2:0];
            be_n_in <= be_tab[r[6:4]];
            cmd_req <= r[11:8];
            cmd_in <= r[15:12];
            reg_rd_data <= r[23:16];
            sd_in <= r[31:24];
            mem_addr <= {q[23:20] & {4{q[19]}}, q[19:0]};
            {reg_io_rd, inta_cycle} <= q[25:24];
            reg_io_wr <= q[25:24] == 2'b00;
            {ex32_n, ex16_n, isa_tgt_internal, int_ready} <= q[29:26];
            {chrdy_in, iochk_n, nmi_enable, addr_valid} <= {q[31:30], r[3], r[7]};
            settle();
            chk("be_from_lane", be_of(lane_in), be_n_out);
            chk("isa_oe", 3'b100, {be_oe, lane_oe, cmd_oe});
            chk("m16_oe", !(ex32_n && ex16_n), m16_oe);
            if (m16_oe === 1'b1) chk("m16_level", 0, m16_n_out);
            chk("cmd_seen", cmd_in, cmd_seen);
            chk("chrdy_oe", isa_tgt_internal, chrdy_oe);
            if (isa_tgt_internal) chk("chrdy_out", int_ready, chrdy_out);
            else chk("chrdy_ignored", 1, chrdy_seen);
            chk("bale_isa", 1, bale);
            @(posedge clk);
            owner <= EBT_OWN_EISA;
            settle();
            sx = {cmd_req.mrd_n | (|mem_addr[23:20]), cmd_req.mwr_n | (|mem_addr[23:20])};
            chk("lane_from_be", lane_of(be_n_in), lane_out);
            chk("eisa_oe", 3'b011, {be_oe, lane_oe, cmd_oe});
            chk("cmd_out", cmd_req, cmd_out);
            chk("sys_strobes", sx, {smrd_n, smwr_n});
            chk("m16_eisa", 0, m16_oe);
            chk("chrdy_seen", chrdy_in, chrdy_seen);
            chk("bale_eisa", addr_valid, bale);
            chk("nmi", ~iochk_n & nmi_enable, nmi);
            chk("sd_oe", reg_io_rd | inta_cycle, sd_oe);
            if (sd_oe === 1'b1) chk("sd_out", reg_rd_data, sd_out);
            else chk("reg_wr_data", sd_in, reg_wr_data);
            chk("reg_wr_stb", reg_io_wr, reg_wr_stb);
            chk("io16_oe", 2'b10, {io16_n_out, io16_oe});
        end
        $display("random translation test done");
        for (i = 0; i < 3; i++) begin
            @(posedge clk);
            owner <= (i == 2) ? EBT_OWN_REF_INT : EBT_OWN_EISA;
            cmd_req <= '{mrd_n: 1'b0, mwr_n: 1'b1, iord_n: 1'b1, iowr_n: 1'b1};
            mem_addr <= (i == 0) ? 24'h0fffff : 24'h100000;
            addr_valid <= 1'b0;
            settle();
            chk("smrd_edge", i == 1, smrd_n);
            chk("refresh_rd", 2'b10, {cmd_oe, cmd_out.mrd_n});
        end
        chk("bale_refresh", 1, bale);
        $display("boundary and refresh test done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
